/* File: rtl/rltr_pkg.sv */
package rltr_pkg;

  // region geometry
  localparam int NUM_PIXELS = 4;                  // pixels sharing one region
  localparam int NUM_SLOTS  = 8;                  // latency memories per region
  localparam int SLOT_W     = 3;                  // bits to address a slot
  localparam int STAMP_W    = 9;                  // timestamp / trigger id width
  localparam int PW_W       = 4;                  // stored pulse-width code width

  // fixed values
  localparam logic [PW_W-1:0]    PW_UNHIT    = 4'hF;   // code for a pixel not hit in this event
  localparam logic [STAMP_W-1:0] STAMP_RESET = 9'h000; // slot value after reset
  localparam logic [SLOT_W-1:0]  SLOT_NONE   = 3'h0;   // slot index when nothing selected
  localparam int                 MAX_LATENCY = 511;    // deepest latency a 9-bit stamp covers

  // per-slot state, two bits
  typedef enum logic [1:0] {
    SLOT_IDLE      = 2'b00,  // free, may take a new hit
    SLOT_PENDING   = 2'b01,  // timestamp stored, latency running
    SLOT_TRIGGERED = 2'b10,  // relabelled with trigger id, waiting for readout
    SLOT_CLEAR     = 2'b11   // read in second-level mode or truncated, waiting for a clear
  } rltr_slot_state_t;

  // trigger presented at latency expiry
  typedef struct packed {
    logic               present;  // trigger seen for the expiring crossing
    logic [STAMP_W-1:0] id;       // label written over the timestamp
  } rltr_trigger_t;

  // one readout word for the region
  typedef struct packed {
    logic [SLOT_W-1:0]                 slot;      // slot that was read
    logic [NUM_PIXELS-1:0]             hit_mask;  // pixels with a real code
    logic [NUM_PIXELS-1:0][PW_W-1:0]   pw_code;   // codes, unhit ones forced to zero
  } rltr_read_word_t;

endpackage : rltr_pkg

/* File: rtl/rltr_slot.sv */
`timescale 1ns/10ps
module rltr_slot
  import rltr_pkg::*;
(
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rstn,
  // write side
  input  wire logic               write_en,       // new region hit lands here
  input  wire logic [STAMP_W-1:0] write_stamp,    // live crossing counter
  // latency check
  input  wire logic [STAMP_W-1:0] delayed_stamp,  // delayed crossing counter
  input  wire rltr_trigger_t      trigger,        // trigger for the expiring crossing
  // readout side
  input  wire logic [STAMP_W-1:0] requested_id,   // trigger id being read
  input  wire logic               read_done,      // this slot was read this cycle
  input  wire logic               truncate,       // event truncated during read
  input  wire logic               second_level,   // second-level trigger mode
  input  wire logic               clear_strobe,   // clear parked slots
  // status
  output rltr_slot_state_t        state,          // current slot state
  output logic [STAMP_W-1:0]      value,          // stored stamp or trigger id
  output logic                    request_match   // queued and id requested
);

  rltr_slot_state_t   next_state;  // state for next crossing
  logic [STAMP_W-1:0] next_value;  // value for next crossing

  // request compare reuses the same storage as the latency compare
  assign request_match = (state == SLOT_TRIGGERED) && (value == requested_id);

  // next state: store, expire, relabel, read, park
  always_comb begin
    next_state = state;
    next_value = value;
    case (state)
      SLOT_IDLE: begin
        // stays idle until a leading edge is steered here
        if (write_en) begin
          next_value = write_stamp;
          next_state = SLOT_PENDING;
        end
      end
      SLOT_PENDING: begin
        // equality only; the gray counters never glitch through other values
        if (value == delayed_stamp) begin
          if (trigger.present) begin
            next_value = trigger.id;
            next_state = SLOT_TRIGGERED;
          end else begin
            next_state = SLOT_IDLE;
          end
        end
      end
      SLOT_TRIGGERED: begin
        // after readout the slot is free unless it must wait for a clear
        if (read_done) begin
          next_state = (second_level || truncate) ? SLOT_CLEAR : SLOT_IDLE;
        end
      end
      SLOT_CLEAR: begin
        if (clear_strobe) begin
          next_state = SLOT_IDLE;
        end
      end
      default: begin
        next_state = SLOT_IDLE;
      end
    endcase
  end

  // register the slot
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= SLOT_IDLE;
      value <= STAMP_RESET;
    end else begin
      state <= next_state;
      value <= next_value;
    end
  end

endmodule : rltr_slot

/* File: rtl/rltr_latency_trigger_readout.sv */
`timescale 1ns/10ps
module rltr_latency_trigger_readout
  import rltr_pkg::*;
(
  // clock and reset
  input  wire logic                              clk_sys,
  input  wire logic                              rstn,
  // pixel hit side
  input  wire logic [NUM_PIXELS-1:0]             hit_leading_edge,
  input  wire logic [NUM_PIXELS-1:0]             hit_trailing_edge,   // conversion end or max
  input  wire logic [NUM_PIXELS-1:0][PW_W-1:0]   time_over_threshold,
  // global counters and trigger
  input  wire logic [STAMP_W-1:0]                crossing_counter,
  input  wire logic [STAMP_W-1:0]                delayed_crossing_counter,
  input  wire rltr_trigger_t                     trigger,
  input  wire logic [STAMP_W-1:0]                requested_id,
  // mode and clearing
  input  wire logic                              second_level_mode,
  input  wire logic                              truncate,
  input  wire logic                              clear_strobe,
  // token chain
  input  wire logic                              token_in,
  output logic                                   token_out,
  output logic                                   token_hold,
  // store select
  output logic [SLOT_W-1:0]                      store_slot,
  output logic                                   store_slot_valid,
  output logic                                   hit_dropped,
  // readout
  output logic [SLOT_W-1:0]                      read_slot,
  output logic                                   read_valid,
  output rltr_read_word_t                        read_word
);

  // lowest set bit of a slot vector, with a found flag on top
  // the loop runs downward so the lowest index is written last and wins;
  // fixed priority keeps allocation and readout order easy to predict
  function automatic logic [SLOT_W:0] first_set(input logic [NUM_SLOTS-1:0] vec);
    logic [SLOT_W:0] res;
    res = {1'b0, SLOT_NONE};
    for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
      if (vec[i]) begin
        res = {1'b1, i[SLOT_W-1:0]};
      end
    end
    return res;
  endfunction : first_set

  // slot status
  // states and values come straight from the eight slot instances
  rltr_slot_state_t       slot_state [NUM_SLOTS];  // per-slot state
  logic [STAMP_W-1:0]     slot_value [NUM_SLOTS];  // per-slot stamp or id
  logic [NUM_SLOTS-1:0]   slot_busy;               // slot not idle
  logic [NUM_SLOTS-1:0]   slot_match;              // queued and requested
  logic [NUM_SLOTS-1:0]   slot_write;              // one-hot write strobe
  logic [NUM_SLOTS-1:0]   slot_read;               // one-hot read strobe

  // allocation and readout picks
  // both searches are pure logic on the current slot states
  logic                   region_hit;              // any pixel leading edge
  logic [SLOT_W:0]        alloc_pick;              // free slot search
  logic [SLOT_W:0]        read_pick;               // matching slot search
  logic                   alloc_ok;                // hit gets a slot
  logic                   read_fire;               // token held this cycle

  // pulse-width storage, per pixel
  // each pixel owns eight locations, one wired to each latency slot
  logic [PW_W-1:0]        pw_mem       [NUM_PIXELS][NUM_SLOTS];
  logic [PW_W-1:0]        next_pw_mem  [NUM_PIXELS][NUM_SLOTS];
  logic [SLOT_W-1:0]      pix_slot      [NUM_PIXELS];  // slot fixed at conversion start
  logic [SLOT_W-1:0]      next_pix_slot [NUM_PIXELS];
  logic [NUM_PIXELS-1:0]  pix_armed;                   // conversion owns a slot
  logic [NUM_PIXELS-1:0]  next_pix_armed;

  // registered outputs
  // data outputs come from flops; only the token pair is combinational
  logic [SLOT_W-1:0]      next_store_slot;
  logic                   next_store_slot_valid;
  logic                   next_hit_dropped;
  logic [SLOT_W-1:0]      next_read_slot;
  logic                   next_read_valid;
  rltr_read_word_t        next_read_word;

  // one region hit takes one slot, however many pixels fired
  // a full region drops the whole hit instead of stealing a pending slot,
  // so stored events are never disturbed by late arrivals
  assign region_hit = |hit_leading_edge;
  assign alloc_pick = first_set(~slot_busy);
  assign alloc_ok   = region_hit && alloc_pick[SLOT_W];
  assign read_pick  = first_set(slot_match);
  assign read_fire  = token_in && read_pick[SLOT_W];

  // token stops here while a matching slot is read, else it moves on
  // both token outputs are combinational, so a region with nothing to
  // read adds no clock of delay to the scan along the column
  assign token_hold = read_fire;
  assign token_out  = token_in && !read_pick[SLOT_W];

  // eight latency memories, each with its own comparator
  // a stored stamp and one comparator cost less power than eight running
  // latency counters; the stamp stays still while the global counters move
  for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
    assign slot_busy[s]  = (slot_state[s] != SLOT_IDLE);
    assign slot_write[s] = alloc_ok && (alloc_pick[SLOT_W-1:0] == SLOT_W'(s));
    assign slot_read[s]  = read_fire && (read_pick[SLOT_W-1:0] == SLOT_W'(s));

    rltr_slot u_slot (
      .clk_sys       (clk_sys),
      .rstn          (rstn),
      .write_en      (slot_write[s]),
      .write_stamp   (crossing_counter),
      .delayed_stamp (delayed_crossing_counter),
      .trigger       (trigger),
      .requested_id  (requested_id),
      .read_done     (slot_read[s]),
      .truncate      (truncate),
      .second_level  (second_level_mode),
      .clear_strobe  (clear_strobe),
      .state         (slot_state[s]),
      .value         (slot_value[s]),
      .request_match (slot_match[s])
    );
  end

  // storage next values: seed a new slot as unhit, write codes at conversion end
  // seeding at allocation means a pixel that never fires in this slot reads
  // back as unhit, so no separate per-slot hit mask has to be kept
  always_comb begin
    next_pw_mem    = pw_mem;
    next_pix_slot  = pix_slot;
    next_pix_armed = pix_armed;
    if (alloc_ok) begin
      // every pixel starts unhit in a fresh slot
      for (int p = 0; p < NUM_PIXELS; p++) begin
        next_pw_mem[p][alloc_pick[SLOT_W-1:0]] = PW_UNHIT;
      end
    end
    for (int p = 0; p < NUM_PIXELS; p++) begin
      if (hit_leading_edge[p]) begin
        // a dropped hit leaves its pixel disarmed so nothing is overwritten
        next_pix_slot[p]  = alloc_pick[SLOT_W-1:0];
        next_pix_armed[p] = alloc_ok;
      end else if (hit_trailing_edge[p] && pix_armed[p]) begin
        next_pw_mem[p][pix_slot[p]] = time_over_threshold[p];
        next_pix_armed[p]            = 1'b0;
      end
    end
  end

  // output next values: store select and readout word
  // the word is built from the memory before the slot is freed, so the
  // slot may be handed out again in the very next cycle without data loss
  always_comb begin
    next_store_slot       = store_slot;
    next_store_slot_valid = alloc_ok;
    next_hit_dropped      = region_hit && !alloc_ok;
    next_read_slot        = read_slot;
    next_read_valid       = read_fire;
    next_read_word        = read_word;
    if (alloc_ok) begin
      next_store_slot = alloc_pick[SLOT_W-1:0];
    end
    if (read_fire) begin
      next_read_slot      = read_pick[SLOT_W-1:0];
      next_read_word.slot = read_pick[SLOT_W-1:0];
      for (int p = 0; p < NUM_PIXELS; p++) begin
        // unhit pixels never reach the output, so codes span 0 to 14
        next_read_word.hit_mask[p] = (pw_mem[p][read_pick[SLOT_W-1:0]] != PW_UNHIT);
        next_read_word.pw_code[p]  = next_read_word.hit_mask[p] ? pw_mem[p][read_pick[SLOT_W-1:0]] : '0;
      end
    end
  end

  // register storage and outputs
  // memories reset to unhit so a stray read never shows a code
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (int p = 0; p < NUM_PIXELS; p++) begin
        for (int s = 0; s < NUM_SLOTS; s++) begin
          pw_mem[p][s] <= PW_UNHIT;
        end
        pix_slot[p] <= SLOT_NONE;
      end
      pix_armed        <= '0;
      store_slot       <= SLOT_NONE;
      store_slot_valid <= 1'b0;
      hit_dropped      <= 1'b0;
      read_slot        <= SLOT_NONE;
      read_valid       <= 1'b0;
      read_word        <= '0;
    end else begin
      pw_mem           <= next_pw_mem;
      pix_slot         <= next_pix_slot;
      pix_armed        <= next_pix_armed;
      store_slot       <= next_store_slot;
      store_slot_valid <= next_store_slot_valid;
      hit_dropped      <= next_hit_dropped;
      read_slot        <= next_read_slot;
      read_valid       <= next_read_valid;
      read_word        <= next_read_word;
    end
  end

  // checks
  // per-slot relations mostly watch slot 0, which every scenario uses;
  // the generate block below repeats the key ones for all eight slots
  // pixel-side checks watch pixel 0 for the same reason
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_one_write: assert property (region_hit |-> $onehot0(slot_write))
    else $error("more than one slot written for one region hit");
  a_alloc_idle: assert property (alloc_ok |-> slot_state[alloc_pick[SLOT_W-1:0]] == SLOT_IDLE)
    else $error("hit steered into an occupied slot");
  a_drop_full: assert property (region_hit && (&slot_busy) |=> hit_dropped && !store_slot_valid)
    else $error("full region did not drop the hit");
  a_write_pending: assert property (store_slot_valid |-> slot_state[store_slot] == SLOT_PENDING
                                    && slot_value[store_slot] == $past(crossing_counter))
    else $error("written slot not pending with the live stamp");
  a_release_free: assert property (slot_state[0] == SLOT_PENDING && slot_value[0] == delayed_crossing_counter
                                   && !trigger.present |=> slot_state[0] == SLOT_IDLE)
    else $error("expired slot without trigger not released");
  a_relabel_id: assert property (slot_state[0] == SLOT_PENDING && slot_value[0] == delayed_crossing_counter
                                 && trigger.present |=> slot_state[0] == SLOT_TRIGGERED
                                 && slot_value[0] == $past(trigger.id))
    else $error("triggered slot not relabelled with the trigger id");
  a_read_word: assert property (read_fire |=> read_valid && read_word.slot == $past(read_pick[SLOT_W-1:0])
                                && read_slot == read_word.slot)
    else $error("read word does not name the matching slot");
  a_token_pass: assert property (token_in && slot_match == '0 |-> token_out && !token_hold)
    else $error("token held with nothing to read");
  a_read_frees: assert property (slot_read[0] && !second_level_mode && !truncate
                                 |=> slot_state[0] == SLOT_IDLE)
    else $error("read slot not returned to idle");
  a_clear_cause: assert property (slot_state[0] == SLOT_CLEAR && $changed(slot_state[0])
                                  |-> $past(second_level_mode) || $past(truncate))
    else $error("clear state entered without cause");
  a_unhit_hidden: assert property (read_valid && !read_word.hit_mask[0] |-> read_word.pw_code[0] == '0)
    else $error("unhit pixel code leaked to readout");

  // a refused hit must leave every slot alone
  a_drop_nowrite: assert property (region_hit && !alloc_ok |-> slot_write == '0)
    else $error("dropped hit still wrote a slot");
  // a fresh slot reads back as unhit before any conversion ends
  a_seed_unhit: assert property (alloc_ok
                                 |=> pw_mem[0][$past(alloc_pick[SLOT_W-1:0])] == PW_UNHIT)
    else $error("fresh slot not seeded as unhit");
  // conversion end lands in the slot fixed at its leading edge
  a_code_store: assert property (hit_trailing_edge[0] && pix_armed[0] && !hit_leading_edge[0]
                                 |=> pw_mem[0][$past(pix_slot[0])] == $past(time_over_threshold[0]))
    else $error("conversion code not stored in its own slot");
  // the store select stays put while the conversion runs
  a_slot_fixed: assert property (pix_armed[0] && !hit_leading_edge[0] |=> pix_slot[0] == $past(pix_slot[0]))
    else $error("store select moved during a conversion");
  // only one slot is read per cycle
  a_read_one: assert property ($onehot0(slot_read))
    else $error("more than one slot read in one cycle");
  // the token is either held or passed on, and only when it is here
  a_token_excl: assert property (!(token_hold && token_out) && (token_in || !token_hold))
    else $error("token held and passed at once");
  // a read in second-level mode or with truncation parks the slot
  a_read_parks: assert property (slot_read[0] && (second_level_mode || truncate)
                                 |=> slot_state[0] == SLOT_CLEAR)
    else $error("read slot not parked for clearing");
  // a parked slot leaves on the clear strobe
  a_clear_frees: assert property (slot_state[0] == SLOT_CLEAR && clear_strobe |=> slot_state[0] == SLOT_IDLE)
    else $error("parked slot not freed by the clear strobe");

  // every slot answers a latency match and holds its trigger until read
  for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot_chk
    // a pending slot must leave pending on its match
    a_expire_any: assert property (slot_state[s] == SLOT_PENDING && slot_value[s] == delayed_crossing_counter
                                   |=> slot_state[s] != SLOT_PENDING)
      else $error("pending slot ignored a latency match");
    // a triggered slot waits for its read
    a_ready_wait: assert property (slot_state[s] == SLOT_TRIGGERED && !slot_read[s]
                                   |=> slot_state[s] == SLOT_TRIGGERED)
      else $error("triggered slot left without a read");
  end

  c_read_out:  cover property (read_fire ##1 read_valid && read_word.hit_mask != '0);
  c_drop_hit:  cover property (hit_dropped);
  c_relabel:   cover property (slot_state[0] == SLOT_PENDING ##1 slot_state[0] == SLOT_TRIGGERED);
  c_park:      cover property (slot_state[0] == SLOT_CLEAR ##[1:20] slot_state[0] == SLOT_IDLE);
  c_truncate:  cover property (slot_read[0] && truncate);

endmodule : rltr_latency_trigger_readout

/* File: dv/rltr_far_model.sv */
`timescale 1ns/10ps
// far side of the region: the global gray counters and the token from the region upstream
module rltr_far_model
  import rltr_pkg::*;
#(
  parameter int LAT = 40  // trigger latency in crossings, kept short for the run
)
(
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rstn,
  // token from the region upstream
  input  wire logic               give_token,
  output logic                    token_in,
  // global counters
  output logic [STAMP_W-1:0]      crossing_counter,
  output logic [STAMP_W-1:0]      delayed_crossing_counter
);
  logic [STAMP_W-1:0] count;  // binary crossing count behind the gray outputs

  // binary to gray, so one bit moves per crossing
  function automatic logic [STAMP_W-1:0] to_gray(input logic [STAMP_W-1:0] b);
    return b ^ (b >> 1);
  endfunction : to_gray

  // count moves at the falling edge, away from the sampling edge
  always @(negedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      count <= STAMP_RESET;
    end else begin
      count <= count + 9'h001;
    end
  end

  // live and delayed counters; wrap-around subtraction gives the lag
  assign crossing_counter         = to_gray(count);
  assign delayed_crossing_counter = to_gray(count - STAMP_W'(LAT));

  // upstream region hands its token straight on
  assign token_in = give_token;
endmodule : rltr_far_model

/* File: dv/rltr_latency_trigger_readout_tb_top.sv */
`timescale 1ns/10ps
module rltr_latency_trigger_readout_tb_top;
  import rltr_pkg::*;
  localparam int                 LAT     = 40;      // short latency keeps the run brief
  localparam logic [STAMP_W-1:0] TRIG_ID = 9'h1A5;  // label given to the triggered event
  // design inputs
  logic                             clk_sys, rstn, second_level_mode, truncate, clear_strobe, give_token;
  logic [NUM_PIXELS-1:0]            hit_leading_edge, hit_trailing_edge;
  logic [NUM_PIXELS-1:0][PW_W-1:0]  time_over_threshold;
  logic [STAMP_W-1:0]               crossing_counter, delayed_crossing_counter, requested_id;
  rltr_trigger_t                    trigger;
  // design outputs
  logic                             token_in, token_out, token_hold, store_slot_valid, hit_dropped, read_valid;
  logic [SLOT_W-1:0]                store_slot, read_slot;
  rltr_read_word_t                  read_word;
  // bookkeeping
  int                               n_mismatch, cmp_count, cycles;

  rltr_far_model #(.LAT(LAT)) i_far (.clk_sys(clk_sys), .rstn(rstn), .give_token(give_token),
    .token_in(token_in), .crossing_counter(crossing_counter), .delayed_crossing_counter(delayed_crossing_counter));

  rltr_latency_trigger_readout i_dut (.clk_sys(clk_sys), .rstn(rstn), .hit_leading_edge(hit_leading_edge),
    .hit_trailing_edge(hit_trailing_edge), .time_over_threshold(time_over_threshold),
    .crossing_counter(crossing_counter), .delayed_crossing_counter(delayed_crossing_counter),
    .trigger(trigger), .requested_id(requested_id), .second_level_mode(second_level_mode),
    .truncate(truncate), .clear_strobe(clear_strobe), .token_in(token_in), .token_out(token_out),
    .token_hold(token_hold), .store_slot(store_slot), .store_slot_valid(store_slot_valid),
    .hit_dropped(hit_dropped), .read_slot(read_slot), .read_valid(read_valid), .read_word(read_word));

  // free-running clock, 8 ns period
  always #4 clk_sys = ~clk_sys;

  // watchdog: the whole run needs a few hundred cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      $display("unexpected at %0t: run did not finish", $time);
      report_and_stop();
    end
  end

  // one comparison; case inequality so an unknown never passes
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask : check

  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : idle

  // one-cycle leading-edge pulse, then judge the allocation answer
  task automatic hit(input logic [3:0] mask, input logic [2:0] slot, input logic drop);
    @(negedge clk_sys);
    hit_leading_edge = mask;
    @(negedge clk_sys);
    hit_leading_edge = '0;
    check(32'(hit_dropped), 32'(drop), "drop flag");
    check(32'(store_slot_valid), 32'(!drop), "store valid");
    if (!drop) check(32'(store_slot), 32'(slot), "store slot");
  endtask : hit

  // conversion end on one pixel with its code
  task automatic conv_end(input int p, input logic [3:0] code);
    @(negedge clk_sys);
    hit_trailing_edge[p]   = 1'b1;
    time_over_threshold[p] = code;
    @(negedge clk_sys);
    hit_trailing_edge = '0;
  endtask : conv_end

  // give the token with a matching request and judge the readout word
  task automatic read_event(input logic [2:0] slot, input logic [3:0] mask, input logic [15:0] codes);
    rltr_read_word_t exp;
    exp.slot     = slot;
    exp.hit_mask = mask;
    exp.pw_code  = codes;
    @(negedge clk_sys);
    requested_id = TRIG_ID;
    give_token   = 1'b1;
    #1;
    check(32'(token_hold), 32'h1, "token held");
    check(32'(token_out), 32'h0, "token kept");
    @(negedge clk_sys);
    check(32'(read_valid), 32'h1, "read valid");
    check(32'(read_slot), 32'(slot), "read slot");
    check(32'(read_word), 32'(exp), "read word");
    check(32'(token_out), 32'h1, "token passed on");
    give_token = 1'b0;
  endtask : read_event

  // shared slot for simultaneous pixels, new slot per edge, release on expiry
  task automatic t_share_and_free;
    hit(4'h3, 3'h0, 1'b0);
    hit(4'h4, 3'h1, 1'b0);
    idle(LAT + 4);
    hit(4'h8, 3'h0, 1'b0);
    idle(LAT + 4);
  endtask : t_share_and_free

  // eight slots fill, the ninth hit is refused, all come back after latency
  task automatic t_full;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      hit(4'(1 << (i % 4)), 3'(i), 1'b0);
    end
    hit(4'hF, 3'h0, 1'b1);
    idle(LAT + 4);
    hit(4'h2, 3'h0, 1'b0);
    idle(LAT + 4);
  endtask : t_full

  // triggered event: relabel, no read without token, wrong id passes token, slot returns
  task automatic t_trigger;
    hit(4'h5, 3'h0, 1'b0);
    conv_end(0, 4'h5);
    conv_end(2, 4'hE);
    trigger = {1'b1, TRIG_ID};
    idle(LAT + 4);
    trigger      = '0;
    requested_id = TRIG_ID;
    repeat (3) begin
      @(negedge clk_sys);
      check(32'(read_valid), 32'h0, "read without token");
    end
    requested_id = TRIG_ID ^ 9'h001;
    give_token   = 1'b1;
    #1;
    check(32'(token_hold), 32'h0, "hold on wrong id");
    check(32'(token_out), 32'h1, "pass on wrong id");
    @(negedge clk_sys);
    give_token = 1'b0;
    read_event(3'h0, 4'h5, 16'h0E05);
    hit(4'h1, 3'h0, 1'b0);
    idle(LAT + 4);
  endtask : t_trigger

  // second-level mode, or a truncated read, parks the read slot until the clear strobe
  task automatic t_park(input logic lvl2);
    second_level_mode = lvl2;
    hit(4'h2, 3'h0, 1'b0);
    conv_end(1, 4'h7);
    trigger = {1'b1, TRIG_ID};
    idle(LAT + 4);
    trigger  = '0;
    truncate = !lvl2;
    read_event(3'h0, 4'h2, 16'h0070);
    truncate = 1'b0;
    hit(4'h1, 3'h1, 1'b0);
    @(negedge clk_sys);
    clear_strobe = 1'b1;
    @(negedge clk_sys);
    clear_strobe = 1'b0;
    hit(4'h1, 3'h0, 1'b0);
    second_level_mode = 1'b0;
    idle(LAT + 4);
  endtask : t_park

  // verdict and end of run
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // main sequence; parking is exercised through second-level mode and through truncation
  initial begin
    clk_sys = 1'b0;
    rstn = 1'b0;
    second_level_mode = 1'b0;
    truncate = 1'b0;
    clear_strobe = 1'b0;
    give_token = 1'b0;
    hit_leading_edge = '0;
    hit_trailing_edge = '0;
    time_over_threshold = '0;
    requested_id = '0;
    trigger = '0;
    n_mismatch = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    rstn = 1'b1;
    t_share_and_free();
    t_full();
    t_trigger();
    t_park(1'b1);
    t_park(1'b0);
    report_and_stop();
  end
endmodule : rltr_latency_trigger_readout_tb_top
